/* design/cmbp_boot_mode.sv */
// byte boot mode tracker
`timescale 1ns/1ps
module cmbp_boot_mode
  import cmbp_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic byte_boot_select,
  output logic      byte_boot_status_bit,
  cmbp_if.tracker   bm
);
  // ============================================================
  // strap capture and recovery count
  logic       started_r;
  logic       status_r;
  logic       fetch_byte_r;
  logic [2:0] nop_cnt_r;
  logic [2:0] nop_cnt_nxt;
  wire        cleared = bm.status_write && !bm.status_bit_val;

  assign nop_cnt_nxt = (status_r || fetch_byte_r) && !status_r && bm.nop_retired ?
                       3'(nop_cnt_r + 3'h1) : nop_cnt_r;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      started_r    <= 1'b0;
      status_r     <= 1'b0;
      fetch_byte_r <= 1'b0;
      nop_cnt_r    <= 3'h0;
    end
    else if (!started_r)
    begin
      started_r    <= 1'b1;
      status_r     <= byte_boot_select; // see R3
      fetch_byte_r <= byte_boot_select;
    end
    else
    begin
      if (cleared)
      begin
        status_r  <= 1'b0; // see R6
        nop_cnt_r <= 3'h0;
      end
      else if (fetch_byte_r && !status_r)
      begin
        nop_cnt_r <= nop_cnt_nxt;
        if (nop_cnt_nxt == BOOT_NOP_COUNT)
          fetch_byte_r <= 1'b0; // see R6
      end
    end
  end

  assign byte_boot_status_bit = status_r;
  assign bm.boot_active       = fetch_byte_r;

  chk_boot_clear_sticks : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R6
    started_r && cleared |=> !status_r) else $error("status bit not cleared");
  chk_boot_word_return : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R6
    $fell(fetch_byte_r) |-> !status_r && $past(nop_cnt_nxt) == BOOT_NOP_COUNT)
    else $error("byte fetch ended early");
endmodule

/* design/cmbp_if.sv */
// internal carrier between the bus port and its boot mode tracker
`timescale 1ns/1ps
interface cmbp_if;
  logic boot_active;
  logic nop_retired;
  logic status_write;
  logic status_bit_val;
  modport tracker (output boot_active, input nop_retired, input status_write, input status_bit_val);
  modport port (input boot_active, output nop_retired, output status_write, output status_bit_val);
endinterface

/* design/cmbp_pkg.sv */
// constants of the core memory bus port
package cmbp_pkg;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned ADDR_W        = 30;
  localparam logic [1:0]  ACK_IDLE      = 2'h0;
  localparam logic [1:0]  ACK_VALID     = 2'h1;
  localparam logic [1:0]  ACK_MEM_ERR   = 2'h2;
  localparam logic [1:0]  ACK_IO_ERR    = 2'h3;
  localparam logic [1:0]  SIZE_BYTE     = 2'h0;
  localparam logic [1:0]  SIZE_HALF     = 2'h1;
  localparam logic [1:0]  SIZE_WORD     = 2'h2;
  localparam logic [1:0]  SIZE_RSVD     = 2'h3;
  localparam logic [3:0]  KIND_NC_IFETCH = 4'h2;
  localparam logic [3:0]  KIND_IC_FILL   = 4'h0;
  localparam logic [3:0]  KIND_DC_FILL   = 4'h4;
  localparam logic [3:0]  KIND_DC_WB     = 4'h5;
  localparam logic [3:0]  KIND_NC_LOAD   = 4'h6;
  localparam logic [3:0]  KIND_NC_STORE  = 4'h7;
  localparam logic [3:0]  KIND_SM_FILL   = 4'hc;
  localparam logic [3:0]  KIND_SM_WB     = 4'hd;
  localparam logic [3:0]  KIND_SM_LOAD   = 4'he;
  localparam logic [3:0]  KIND_SM_STORE  = 4'hf;
  localparam int unsigned BOOT_STATUS_BIT = 14;
  localparam logic [2:0]  BOOT_NOP_COUNT  = 3'h4;
  localparam logic [2:0]  BURST_BEATS     = 3'h4;
  localparam logic [2:0]  SINGLE_BEATS    = 3'h1;
endpackage

/* design/cmbp_top.sv */
// memory side transaction port of the core
`timescale 1ns/1ps
// How it works
// R1 - 32-bit big-endian bus, address plus size
// R2 - narrow or wide devices steer lanes
// R3 - strap high gives byte fetch, status bit
// R4 - boot byte taken from bits 31:24
// R5 - strap held constant after reset
// R6 - clearing bit 14 ends boot after nops
// R7 - request held until acknowledge sampled
// R8 - reads wait indefinitely; valid stays for pending
// R9 - back to back: valid stays, strobe pulses
// R10 - read data valid with acknowledge
// R11 - next transaction right after last beat
// R12 - write data advances on each acknowledge
// R13 - no turnaround cycles
// R14 - single noncached access gets one ack
// R15 - no snoop or register access path
// R16 - acknowledge codes idle, valid, two errors
// R17 - size codes byte, half, word, reserved
// R18 - kind codes identify source and kind
// R19 - error ends burst
// R20 - valid and strobe inactive after reset
module cmbp_top
  import cmbp_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic                byte_boot_select,
  output logic                     byte_boot_status_bit,
  input  wire logic                status_write,
  input  wire logic                status_write_bit,
  input  wire logic                nop_retired,
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire logic [3:0]          req_kind,
  input  wire logic [1:0]          req_size,
  input  wire logic [cmbp_pkg::ADDR_W-1:0] req_address,
  input  wire logic [cmbp_pkg::DATA_W-1:0] req_wdata,
  output logic                     wdata_ready,
  output logic                     transaction_valid,
  output logic                     address_latch_strobe_b,
  output logic [3:0]               request_kind,
  output logic [1:0]               access_size,
  output logic [cmbp_pkg::ADDR_W-1:0] request_address,
  output logic [cmbp_pkg::DATA_W-1:0] write_data_bus,
  input  wire logic [1:0]          transfer_acknowledge,
  input  wire logic [cmbp_pkg::DATA_W-1:0] read_data_bus,
  output logic                     rsp_valid,
  output logic [cmbp_pkg::DATA_W-1:0] rsp_data,
  output logic                     rsp_error,
  output logic                     rsp_last,
  output logic                     boot_fetch_active
);
  // ============================================================
  // boot mode tracker
  cmbp_if bm_if ();

  assign bm_if.nop_retired    = nop_retired;
  assign bm_if.status_write   = status_write;
  assign bm_if.status_bit_val = status_write_bit;

  cmbp_boot_mode u_boot
  (
    .clk_sys              (clk_sys),
    .rst_b                (rst_b),
    .byte_boot_select     (byte_boot_select),
    .byte_boot_status_bit (byte_boot_status_bit),
    .bm                   (bm_if)
  );

  assign boot_fetch_active = bm_if.boot_active;

  // ============================================================
  // transaction state
  typedef enum logic [0:0] {CMBP_IDLE, CMBP_BUSY} cmbp_state_e;

  cmbp_state_e          state_r;
  cmbp_state_e          state_nxt;
  logic                 tv_r;
  logic                 ale_r;
  logic [3:0]           kind_r;
  logic [1:0]           size_r;
  logic [ADDR_W-1:0]    addr_r;
  logic [DATA_W-1:0]    wdata_r;
  logic [2:0]           beats_left_r;
  logic                 rsp_valid_r;
  logic [DATA_W-1:0]    rsp_data_r;
  logic                 rsp_error_r;
  logic                 rsp_last_r;

  // ============================================================
  // decode
  wire       is_burst_kind = (req_kind == KIND_IC_FILL) || (req_kind == KIND_DC_FILL) ||
                             (req_kind == KIND_DC_WB)   || (req_kind == KIND_SM_FILL) ||
                             (req_kind == KIND_SM_WB);
  wire       is_write_kind = (req_kind == KIND_DC_WB) || (req_kind == KIND_NC_STORE) ||
                             (req_kind == KIND_SM_WB) || (req_kind == KIND_SM_STORE);
  wire       cur_burst     = (kind_r == KIND_IC_FILL) || (kind_r == KIND_DC_FILL) ||
                             (kind_r == KIND_DC_WB)   || (kind_r == KIND_SM_FILL) ||
                             (kind_r == KIND_SM_WB);
  wire       cur_write     = (kind_r == KIND_DC_WB) || (kind_r == KIND_NC_STORE) ||
                             (kind_r == KIND_SM_WB) || (kind_r == KIND_SM_STORE);
  wire       is_ifetch     = req_kind == KIND_NC_IFETCH;
  wire       ack_any       = tv_r && (transfer_acknowledge != ACK_IDLE);
  wire       ack_err       = tv_r && transfer_acknowledge[1]; // see R16
  // error in any beat or the final beat ends the transaction
  wire       ack_last      = ack_any && (ack_err || beats_left_r == 3'h1); // see R19
  wire       free_slot     = (state_r == CMBP_IDLE) || ack_last;
  wire       take          = req_valid && free_slot; // see R11
  // byte boot forces noncached instruction fetches to single bytes
  wire [1:0] eff_size      = (is_ifetch && bm_if.boot_active) ? SIZE_BYTE : // see R3
                             (is_ifetch ? SIZE_WORD : req_size); // see R17
  wire [2:0] eff_beats     = is_burst_kind ? BURST_BEATS : SINGLE_BEATS; // see R14
  // sub-word read data sits big-endian; boot bytes come from the top lane
  wire [DATA_W-1:0] lane_data = (size_r == SIZE_BYTE) ? {24'h0, read_data_bus[31:24]} : // see R4
                                (size_r == SIZE_HALF) ? {16'h0, read_data_bus[31:16]} : // see R1
                                read_data_bus;

  assign state_nxt = take ? CMBP_BUSY : (ack_last ? CMBP_IDLE : state_r);
  assign req_ready = free_slot;
  assign wdata_ready = ack_any && cur_write && !ack_last; // see R12

  // ============================================================
  // request side
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r      <= CMBP_IDLE;
      tv_r         <= 1'b0; // see R20
      ale_r        <= 1'b0;
      kind_r       <= KIND_IC_FILL;
      size_r       <= SIZE_WORD;
      addr_r       <= '0;
      wdata_r      <= '0;
      beats_left_r <= 3'h0;
    end
    else
    begin
      state_r <= state_nxt;
      ale_r   <= take; // see R9
      if (take)
      begin
        tv_r         <= 1'b1; // see R7
        kind_r       <= req_kind; // see R18
        size_r       <= eff_size;
        addr_r       <= req_address;
        wdata_r      <= req_wdata; // see R12
        beats_left_r <= eff_beats;
      end
      else if (ack_last)
        tv_r <= 1'b0; // see R8
      else if (ack_any)
      begin
        beats_left_r <= 3'(beats_left_r - 3'h1);
        if (cur_write)
          wdata_r <= req_wdata; // see R12
      end
    end
  end

  // ============================================================
  // response side
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= '0;
      rsp_error_r <= 1'b0;
      rsp_last_r  <= 1'b0;
    end
    else
    begin
      rsp_valid_r <= ack_any;
      rsp_error_r <= ack_err;
      rsp_last_r  <= ack_last;
      if (ack_any && !cur_write)
        rsp_data_r <= lane_data; // see R10
    end
  end

  assign transaction_valid      = tv_r;
  assign address_latch_strobe_b = !ale_r; // see R9
  assign request_kind           = kind_r;
  assign access_size            = size_r;
  assign request_address        = addr_r;
  assign write_data_bus         = wdata_r; // see R13
  assign rsp_valid              = rsp_valid_r;
  assign rsp_data               = rsp_data_r;
  assign rsp_error              = rsp_error_r;
  assign rsp_last               = rsp_last_r;
  // no snoop or register path exists on this port, see R15

  // ============================================================
  // checks
  chk_req_hold_stable : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R7
    tv_r && !ack_any |=> tv_r && $stable(addr_r) && $stable(kind_r) && $stable(size_r))
    else $error("request changed before acknowledge");
  chk_strobe_with_valid : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R9
    ale_r |-> tv_r && $past(take)) else $error("strobe without new request");
  chk_back_to_back : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R9
    ack_last && req_valid |=> tv_r && ale_r) else $error("back to back lost valid");
  chk_valid_drop : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R8
    ack_last && !req_valid |=> !tv_r) else $error("valid held without pending request");
  chk_boot_size_byte : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R3
    ale_r && kind_r == KIND_NC_IFETCH && $past(bm_if.boot_active) |-> size_r == SIZE_BYTE)
    else $error("boot fetch not byte sized");
  chk_boot_lane_top : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R4
    ack_any && !ack_err && !cur_write && size_r == SIZE_BYTE |=> rsp_data_r == {24'h0, $past(read_data_bus[31:24])})
    else $error("byte not from top lane");
  chk_size_legal : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R17
    tv_r && kind_r == KIND_NC_IFETCH |-> size_r != SIZE_RSVD) else $error("reserved size issued");
  chk_write_advance : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R12
    ack_any && cur_write && !ack_last |=> write_data_bus == $past(req_wdata))
    else $error("write data not advanced");
  chk_error_ends : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R19
    ack_err && !req_valid |=> !tv_r && state_r == CMBP_IDLE) else $error("error did not end transaction");
  chk_reset_quiet : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R20
    $rose(tv_r) |-> ale_r) else $error("valid rose without strobe");
  chk_valid_until_done : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R8
    tv_r && !ack_last |=> tv_r) else $error("valid dropped before last acknowledge");
  chk_fields_on_take : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R18
    take |=> kind_r == $past(req_kind) && addr_r == $past(req_address)) else $error("request fields not latched");
  chk_wdata_on_take : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R12
    take |=> write_data_bus == $past(req_wdata)) else $error("write data not presented with request");
  chk_single_beat : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R14
    take && !is_burst_kind |=> beats_left_r == 3'h1) else $error("single access expects extra beats");
  chk_idle_no_valid : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R20
    state_r == CMBP_IDLE |-> !tv_r && !ale_r) else $error("valid or strobe while idle");
  chk_word_fetch : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R6
    ale_r && kind_r == KIND_NC_IFETCH && !$past(bm_if.boot_active) |-> size_r == SIZE_WORD)
    else $error("fetch outside boot not word sized");
  chk_idle_ack_ignored : assert property (@(posedge clk_sys) disable iff (!rst_b) // see R16
    !tv_r |=> !rsp_valid_r) else $error("acknowledge taken with no request");
endmodule

/* dv/cmbp_mem_model.sv */
// memory controller model on the far side of the bus port
`timescale 1ns/1ps
module cmbp_mem_model
  import cmbp_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        rst_b,
  input  wire logic                        transaction_valid,
  input  wire logic                        address_latch_strobe_b,
  input  wire logic [3:0]                  request_kind,
  input  wire logic [cmbp_pkg::ADDR_W-1:0] request_address,
  input  wire logic [cmbp_pkg::DATA_W-1:0] write_data_bus,
  input  wire logic [3:0]                  wait_cycles,
  input  wire logic [2:0]                  err_beat,
  input  wire logic [1:0]                  err_code,
  output logic      [1:0]                  transfer_acknowledge,
  output logic      [cmbp_pkg::DATA_W-1:0] read_data_bus
);
  logic [2:0]        left_r;
  logic [2:0]        beat_r;
  logic [3:0]        wait_r;
  logic [DATA_W-1:0] wlog [4];
  wire               burst = request_kind inside {KIND_IC_FILL, KIND_DC_FILL, KIND_DC_WB, KIND_SM_FILL, KIND_SM_WB};
  wire               go    = (left_r != 3'h0) && (wait_r == 4'h0) && transaction_valid;
  wire               err   = (beat_r == err_beat);
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      left_r               <= 3'h0;
      beat_r               <= 3'h0;
      wait_r               <= 4'h0;
      transfer_acknowledge <= ACK_IDLE;
      read_data_bus        <= 32'h0;
    end
    else
    begin
      if (transfer_acknowledge != ACK_IDLE)
        wlog[beat_r - 3'h1] <= write_data_bus;
      if (!address_latch_strobe_b)
      begin
        left_r <= burst ? BURST_BEATS : SINGLE_BEATS;
        beat_r <= 3'h0;
        wait_r <= wait_cycles;
      end
      else if (wait_r != 4'h0)
        wait_r <= wait_r - 4'h1;
      // beats follow each other with no gap; idle data keeps changing
      transfer_acknowledge <= go ? (err ? err_code : ACK_VALID) : ACK_IDLE;
      read_data_bus <= go ? {request_address[7:0] + 8'(beat_r), 24'hc3a55a} : ~read_data_bus;
      if (go)
      begin
        left_r <= err ? 3'h0 : left_r - 3'h1;
        beat_r <= beat_r + 3'h1;
      end
    end
  end
endmodule

/* dv/testbench.sv */
// self-checking bench for the core memory bus port
`timescale 1ns/1ps
module testbench;
  import cmbp_pkg::*;
  logic              clk_sys = 1'b0;
  logic              rst_b = 1'b0;
  logic              boot_strap = 1'b1;
  logic              status_write = 1'b0;
  logic              status_write_bit = 1'b0;
  logic              nop_retired = 1'b0;
  logic              req_valid = 1'b0;
  logic [3:0]        req_kind = 4'h0;
  logic [1:0]        req_size = 2'h0;
  logic [ADDR_W-1:0] req_address = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic [3:0]        wait_cycles = 4'h0;
  logic [2:0]        err_beat = 3'h7;
  logic [1:0]        err_code = 2'h2;
  logic              byte_boot_status_bit, req_ready, wdata_ready, transaction_valid, address_latch_strobe_b;
  logic              rsp_valid, rsp_error, rsp_last, boot_fetch_active;
  logic [3:0]        request_kind;
  logic [1:0]        access_size, transfer_acknowledge;
  logic [ADDR_W-1:0] request_address;
  logic [DATA_W-1:0] write_data_bus, read_data_bus, rsp_data;
  int                n_mismatch = 0;
  int                total_checks = 0;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (wdata_ready === 1'b1) req_wdata <= req_wdata + 32'h1;
  cmbp_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .byte_boot_select(boot_strap),
    .byte_boot_status_bit(byte_boot_status_bit),
    .status_write(status_write), .status_write_bit(status_write_bit), .nop_retired(nop_retired),
    .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind), .req_size(req_size),
    .req_address(req_address), .req_wdata(req_wdata), .wdata_ready(wdata_ready),
    .transaction_valid(transaction_valid), .address_latch_strobe_b(address_latch_strobe_b),
    .request_kind(request_kind), .access_size(access_size), .request_address(request_address),
    .write_data_bus(write_data_bus), .transfer_acknowledge(transfer_acknowledge), .read_data_bus(read_data_bus),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error), .rsp_last(rsp_last),
    .boot_fetch_active(boot_fetch_active));
  cmbp_mem_model mem (.clk_sys(clk_sys), .rst_b(rst_b), .transaction_valid(transaction_valid),
    .address_latch_strobe_b(address_latch_strobe_b), .request_kind(request_kind),
    .request_address(request_address), .write_data_bus(write_data_bus), .wait_cycles(wait_cycles),
    .err_beat(err_beat), .err_code(err_code), .transfer_acknowledge(transfer_acknowledge),
    .read_data_bus(read_data_bus));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // request held until taken, then the bus start is judged
  task automatic issue(input logic [3:0] k, input logic [1:0] s, input logic [29:0] a, input logic [31:0] wd,
                       input logic hold, input logic [1:0] xs);
    int i;
    @(posedge clk_sys);
    req_valid   <= 1'b1;
    req_kind    <= k;
    req_size    <= s;
    req_address <= a;
    req_wdata   <= wd;
    i = 0;
    #1;
    while (req_ready !== 1'b1 && i < 200)
    begin
      i++;
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    if (i == 200)
    begin
      n_mismatch++;
      final_report();
    end
    req_valid <= hold;
    req_wdata <= wd + 32'h1;
    #1;
    chk("strobe", 32'h0, 32'(address_latch_strobe_b));
    chk("valid", 32'h1, 32'(transaction_valid));
    chk("kind", 32'(k), 32'(request_kind));
    chk("size", 32'(xs), 32'(access_size));
    chk("address", 32'(a), 32'(request_address));
  endtask
  task automatic collect(input logic [29:0] a, input int nb, input int sh, input int eb);
    int i;
    int b;
    b = 0;
    for (i = 0; i < 200 && b < nb; i++)
    begin
      @(posedge clk_sys);
      #1;
      if (rsp_valid === 1'b1)
      begin
        chk("rdata", {a[7:0] + 8'(b), 24'hc3a55a} >> sh, rsp_data & (32'hffffffff >> sh));
        chk("last", 32'(b == nb - 1 || b == eb), 32'(rsp_last));
        chk("error", 32'(b == eb), 32'(rsp_error));
        b = (b == eb) ? nb : b + 1;
      end
      else
        chk("held", 32'h1, 32'(transaction_valid));
    end
    chk("beats", 32'(nb), 32'(b));
    if (b < nb)
      final_report();
    chk("valid", 32'h0, 32'(transaction_valid));
  endtask
  task automatic t_reset();
    repeat (2) @(posedge clk_sys);
    chk("valid", 32'h0, 32'(transaction_valid));
    chk("strobe", 32'h1, 32'(address_latch_strobe_b));
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("boot bit", 32'h1, 32'(byte_boot_status_bit));
  endtask
  task automatic t_boot_fetch();
    issue(KIND_NC_IFETCH, SIZE_WORD, 30'h40, 32'h0, 1'b0, SIZE_BYTE);
    collect(30'h40, 1, 24, 7);
  endtask
  task automatic t_boot_exit();
    int i;
    @(posedge clk_sys);
    status_write     <= 1'b1;
    status_write_bit <= 1'b1;
    @(posedge clk_sys);
    status_write_bit <= 1'b0;
    #1;
    chk("boot bit", 32'h1, 32'(byte_boot_status_bit));
    @(posedge clk_sys);
    status_write <= 1'b0;
    #1;
    chk("boot bit", 32'h0, 32'(byte_boot_status_bit));
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      nop_retired <= 1'b1;
      @(posedge clk_sys);
      nop_retired <= 1'b0;
      #1;
      chk("boot fetch", 32'(i < 3), 32'(boot_fetch_active));
    end
    issue(KIND_NC_IFETCH, SIZE_WORD, 30'h44, 32'h0, 1'b0, SIZE_WORD);
    collect(30'h44, 1, 0, 7);
  endtask
  task automatic t_bursts();
    int k;
    wait_cycles <= 4'h3;
    issue(KIND_DC_FILL, SIZE_WORD, 30'h100, 32'h0, 1'b0, SIZE_WORD);
    collect(30'h100, 4, 0, 7);
    issue(KIND_DC_WB, SIZE_WORD, 30'h200, 32'h10000000, 1'b0, SIZE_WORD);
    collect(30'h200, 4, 32, 7);
    for (k = 0; k < 4; k++)
      chk("wdata", 32'h10000000 + 32'(k), mem.wlog[k]);
    wait_cycles <= 4'h0;
    issue(KIND_NC_STORE, SIZE_HALF, 30'h300, 32'h0000beef, 1'b0, SIZE_HALF);
    collect(30'h300, 1, 32, 7);
    chk("wdata", 32'h0000beef, mem.wlog[0]);
    issue(KIND_NC_LOAD, SIZE_HALF, 30'h310, 32'h0, 1'b0, SIZE_HALF);
    collect(30'h310, 1, 16, 7);
  endtask
  task automatic t_errors();
    int k;
    for (k = 2; k < 4; k++)
    begin
      err_beat <= 3'h1;
      err_code <= 2'(k);
      issue(KIND_SM_FILL, SIZE_WORD, 30'h400, 32'h0, 1'b0, SIZE_WORD);
      collect(30'h400, 4, 0, 1);
    end
    err_beat <= 3'h7;
  endtask
  task automatic t_back_to_back();
    wait_cycles <= 4'h2;
    issue(KIND_NC_LOAD, SIZE_WORD, 30'h500, 32'h0, 1'b1, SIZE_WORD);
    issue(KIND_SM_LOAD, SIZE_WORD, 30'h600, 32'h0, 1'b0, SIZE_WORD);
    chk("last", 32'h1, 32'(rsp_last));
    collect(30'h600, 1, 0, 7);
  endtask
  // strap low across a mid-run reset keeps word fetches
  task automatic t_word_boot();
    @(posedge clk_sys);
    rst_b      <= 1'b0;
    boot_strap <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("valid", 32'h0, 32'(transaction_valid));
    chk("strobe", 32'h1, 32'(address_latch_strobe_b));
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("boot bit", 32'h0, 32'(byte_boot_status_bit));
    chk("boot fetch", 32'h0, 32'(boot_fetch_active));
    issue(KIND_NC_IFETCH, SIZE_BYTE, 30'h48, 32'h0, 1'b0, SIZE_WORD);
    collect(30'h48, 1, 0, 7);
  endtask
  initial
  begin
    t_reset();
    t_boot_fetch();
    t_boot_exit();
    t_bursts();
    t_errors();
    t_back_to_back();
    t_word_boot();
    final_report();
  end
endmodule
